// ==== design/exception_vector_priority_unit.sv ====
// Exception vector priority unit: request collection, priority decode, test forcing
// Notes on behaviour
// - I-masked vectors FF00 to FFF2
// - One X-masked vector at FFF4
// - Software or debug vector at FFF6
// - Opcode trap vector at FFF8
// - Three reset vectors FFFA to FFFE
// - Drive chosen vector on vector fetch
// - Flag core when an I or X request pends
// - Blocking inputs suppress I and X service
// - Wake on unmasked live I line or x pin
// - Wake output for I and X is registered on clk_sys
// - Promoted I source takes top I priority
// - Write enable writable: special, I and X set
// - Enable low: ignore force writes, read inputs
// - Enable high: decode force registers instead
// - Pending requests stay in force registers
// - Select field names vector group nibble
// - Force registers read zero in normal modes
// - Force writes: special, enable, I mask
// - Force bit n is vector FFxN*2
// - One force register per eight vectors
// - Group F: only bits 2:0 exist
// - Unimplemented bits: writes ignored, reads zero
// - Vector follows current highest pending request
// - Never pending: supply software vector
`include "vector_unit_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module exception_vector_priority_unit
	import vector_unit_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Register port
	input wire reg_req_type reg_req,
	output logic [7:0] reg_rdata,
	// Core state
	input wire core_state_type core_state,
	// Request lines, bit k is vector FF00 + 2k (k up to 121 = FFF2)
	input wire logic [`I_SOURCES-1:0] i_request,
	input wire logic x_request_pin,
	input wire logic software_interrupt,
	input wire logic debug_entry_request,
	input wire logic opcode_trap,
	input wire reset_req_type reset_req,
	input wire logic block_i,
	input wire logic block_x,
	// Core vector handshake
	input wire logic vector_fetch,
	output logic [15:0] vector_addr,
	output logic i_pending,
	output logic x_pending,
	// Wake output
	output logic wake_up
);

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic test_write_enable; // Force mode on
	logic [3:0] test_reg_select; // Group selector
	logic [7:0] promoted_sel; // Promoted vector low byte
	logic [7:0] force_reg [0:15]; // One force register per group
	logic [127:0] live_vec; // Live I and X lines per vector slot
	logic [127:0] force_vec; // Force registers flattened
	logic [127:0] eff_vec; // Decoded request set
	logic ever_pending; // Any valid request seen since reset
	logic [15:0] last_vector; // Last valid vector
	logic [7:0] group_live; // Live lines of selected group
	logic [7:0] group_mask; // Implemented bits of selected group
	logic tcr_write_ok; // Enable bit may change
	logic force_write_ok; // Force write accepted

	// Live lines into vector slots: slot k holds vector FF00 + 2k
	assign live_vec = {5'h00, x_request_pin, i_request};
	// Implemented bit mask per group; group F stops at FFF4
	assign group_mask = (test_reg_select == `LAST_GROUP) ? `LAST_GROUP_MASK : 8'hFF;
	assign group_live = live_vec[{test_reg_select, 3'h0} +: 8] & group_mask;
	assign tcr_write_ok = core_state.special_mode & core_state.i_mask & core_state.x_mask;
	assign force_write_ok = core_state.special_mode & test_write_enable
		& core_state.i_mask;

	// Flatten the force array; unimplemented bits stay zero
	always_comb
	begin
		for (int g = 0; g < 16; g++)
		begin
			force_vec[g*8 +: 8] = force_reg[g];
		end
	end

	// Decode source: live lines or force registers
	assign eff_vec = test_write_enable ? force_vec : live_vec;

	////////////////////////////////////////////////////////////////////////////
	// Test control register
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			test_write_enable <= 1'b0;
			test_reg_select <= 4'h0;
		end
		else if (reg_req.wr && reg_req.addr == `OFS_TEST_CONTROL)
		begin
			// Select always writable
			test_reg_select <= reg_req.wdata[`TCR_SELECT_MSB:0];
			// Enable only in special mode with both masks set
			if (tcr_write_ok)
			begin
				test_write_enable <= reg_req.wdata[`TCR_WRITE_EN_BIT];
			end
		end
	end

	// Force registers; copy live lines on enable rising so pending ones stay
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 16; i++)
			begin
				force_reg[i] <= `RST_FORCE;
			end
		end
		else if (reg_req.wr && reg_req.addr == `OFS_TEST_CONTROL && tcr_write_ok
			&& reg_req.wdata[`TCR_WRITE_EN_BIT] && !test_write_enable)
		begin
			// Capture pending requests at enable so they remain
			for (int i = 0; i < 16; i++)
			begin
				force_reg[i] <= live_vec[i*8 +: 8];
			end
		end
		else if (reg_req.wr && reg_req.addr == `OFS_TEST_FORCE && force_write_ok)
		begin
			// Group F keeps bits above FFF4 at zero
			force_reg[test_reg_select] <= reg_req.wdata & group_mask;
		end
	end

	// Promoted I source select, written only with I mask set
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			promoted_sel <= `RST_PROMOTED;
		end
		else if (reg_req.wr && reg_req.addr == `OFS_PROMOTED && core_state.i_mask)
		begin
			promoted_sel <= {reg_req.wdata[7:1], 1'b0};
		end
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata <= 8'h00;
		end
		else if (reg_req.rd)
		begin
			case (reg_req.addr)
				`OFS_TEST_CONTROL: reg_rdata <= {3'h0, test_write_enable, test_reg_select};
				`OFS_TEST_FORCE:
				begin
					// Normal modes read zero; live lines unless forcing
					if (!core_state.special_mode)
					begin
						reg_rdata <= 8'h00;
					end
					else if (test_write_enable)
					begin
						reg_rdata <= force_reg[test_reg_select] & group_mask;
					end
					else
					begin
						reg_rdata <= group_live;
					end
				end
				`OFS_PROMOTED: reg_rdata <= promoted_sel;
				default: reg_rdata <= 8'h00;
			endcase
		end
		else
		begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Priority decode
	logic i_any; // Valid unmasked I request
	logic x_valid; // Valid unmasked X request
	logic promoted_valid; // Promoted source active
	logic [6:0] promoted_idx; // Slot of promoted vector
	logic [6:0] top_i_idx; // Highest pending I slot
	logic [15:0] next_vector; // Vector to supply now
	logic next_any; // Any valid request now

	assign promoted_idx = promoted_sel[7:1];
	// Invalid or idle selections fall back to the highest pending I vector
	assign promoted_valid = (promoted_sel <= `VEC_I_TOP) && eff_vec[promoted_idx];

	// Highest I slot is the highest address
	always_comb
	begin
		top_i_idx = 7'h00;
		i_any = 1'b0;
		for (int k = 0; k < `I_SOURCES; k++)
		begin
			if (eff_vec[k])
			begin
				top_i_idx = 7'(k);
				i_any = 1'b1;
			end
		end
		// Blocking inputs and masks suppress service
		i_any = i_any & ~core_state.i_mask & ~block_i;
	end

	assign x_valid = eff_vec[`I_SOURCES] & ~core_state.x_mask & ~block_x;

	// Fixed priority: resets, trap, software, X, then I
	always_comb
	begin
		next_any = 1'b1;
		if (reset_req.sys)
			next_vector = `VEC_SYS_RESET;
		else if (reset_req.clk_mon)
			next_vector = `VEC_CLK_MON_RESET;
		else if (reset_req.watchdog)
			next_vector = `VEC_WATCHDOG_RESET;
		else if (opcode_trap)
			next_vector = `VEC_OPCODE_TRAP;
		else if (software_interrupt || debug_entry_request)
			next_vector = `VEC_SOFTWARE;
		else if (x_valid)
			next_vector = `VEC_X_REQUEST;
		else if (i_any && promoted_valid)
			next_vector = {8'hFF, promoted_sel};
		else if (i_any)
			next_vector = {8'hFF, top_i_idx, 1'b0};
		else
		begin
			// Unknown source: last valid, or software vector if none ever
			next_any = 1'b0;
			next_vector = ever_pending ? last_vector : `VEC_SOFTWARE;
		end
	end

	// Remember last valid vector for a vanished source
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ever_pending <= 1'b0;
			last_vector <= `VEC_SOFTWARE;
		end
		else if (next_any)
		begin
			ever_pending <= 1'b1;
			last_vector <= next_vector;
		end
	end

	// Vector output, latched on the fetch request
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vector_addr <= `VEC_SOFTWARE;
		end
		else if (vector_fetch)
		begin
			vector_addr <= next_vector;
		end
	end

	// Pending flags toward the core
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			i_pending <= 1'b0;
			x_pending <= 1'b0;
		end
		else
		begin
			i_pending <= i_any;
			x_pending <= x_valid;
		end
	end

	// Wake path: raw lines meet no clocked stage before this flop, so the
	// request itself needs no clock; the registered copy needs a running clock
	logic wake_src;
	assign wake_src = (|live_vec[`I_SOURCES-1:0] & ~core_state.i_mask) | x_request_pin;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wake_up <= 1'b0;
		end
		else
		begin
			wake_up <= wake_src;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	fetch_vector_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		vector_fetch |=> vector_addr == $past(next_vector))
		else $error("vector not taken on fetch");
	sys_reset_top_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(vector_fetch && reset_req.sys) |=> vector_addr == `VEC_SYS_RESET)
		else $error("system reset vector lost");
	never_pend_swi_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(vector_fetch && !ever_pending && !next_any) |=> vector_addr == `VEC_SOFTWARE)
		else $error("default vector wrong");
	x_wake_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		x_request_pin |=> wake_up)
		else $error("x pin did not wake");
	block_i_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		block_i |=> !i_pending)
		else $error("blocked I still pending");
	tcr_guard_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!tcr_write_ok |=> $stable(test_write_enable))
		else $error("enable changed unguarded");
	normal_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(reg_req.rd && reg_req.addr == `OFS_TEST_FORCE && !core_state.special_mode)
		|=> reg_rdata == 8'h00)
		else $error("force read nonzero in normal mode");
	group_f_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		force_reg[15][7:3] == 5'h00)
		else $error("group F high bits set");
	i_pend_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(|eff_vec[`I_SOURCES-1:0] && !core_state.i_mask && !block_i) |=> i_pending)
		else $error("I request not flagged");
	x_pend_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(eff_vec[`I_SOURCES] && !core_state.x_mask && !block_x) |=> x_pending)
		else $error("X request not flagged");
	block_x_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		block_x |=> !x_pending)
		else $error("blocked X still pending");
	// Vector choice for trap, software and X classes, lower classes only when higher are idle
	trap_vec_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(vector_fetch && opcode_trap && reset_req == '0) |=> vector_addr == `VEC_OPCODE_TRAP)
		else $error("trap vector lost");
	swi_vec_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(vector_fetch && (software_interrupt || debug_entry_request) && !opcode_trap
		&& reset_req == '0) |=> vector_addr == `VEC_SOFTWARE)
		else $error("software vector lost");
	x_vec_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(vector_fetch && x_valid && !opcode_trap && !software_interrupt
		&& !debug_entry_request && reset_req == '0) |=> vector_addr == `VEC_X_REQUEST)
		else $error("X vector lost");
	// Register guards and read paths
	promote_guard_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(reg_req.wr && reg_req.addr == `OFS_PROMOTED && !core_state.i_mask)
		|=> $stable(promoted_sel))
		else $error("promoted select written unmasked");
	live_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(reg_req.rd && reg_req.addr == `OFS_TEST_FORCE && core_state.special_mode
		&& !test_write_enable) |=> reg_rdata == $past(group_live))
		else $error("force read not live lines");

endmodule : exception_vector_priority_unit
`default_nettype wire

// ==== design/vector_unit_consts.svh ====
// Offsets, field positions, reset values and vector addresses of the vector unit
`ifndef VECTOR_UNIT_CONSTS_SVH
`define VECTOR_UNIT_CONSTS_SVH
`define OFS_TEST_CONTROL 8'h15
`define OFS_TEST_FORCE 8'h16
`define OFS_PROMOTED 8'h1F
`define TCR_WRITE_EN_BIT 4
`define TCR_SELECT_MSB 3
`define RST_TEST_CONTROL 8'h00
`define RST_FORCE 8'h00
`define RST_PROMOTED 8'hF2
`define VEC_SYS_RESET 16'hFFFE
`define VEC_CLK_MON_RESET 16'hFFFC
`define VEC_WATCHDOG_RESET 16'hFFFA
`define VEC_OPCODE_TRAP 16'hFFF8
`define VEC_SOFTWARE 16'hFFF6
`define VEC_X_REQUEST 16'hFFF4
`define VEC_I_TOP 8'hF2
`define LAST_GROUP 4'hF
`define LAST_GROUP_MASK 8'h07
`define I_SOURCES 122
`endif

// ==== design/vector_unit_pkg.sv ====
// Types shared by the exception vector unit
package vector_unit_pkg;
	// Register bus request from software
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
	// Core-side masks and mode
	typedef struct packed {
		logic i_mask;
		logic x_mask;
		logic special_mode;
	} core_state_type;
	// Reset request kinds
	typedef struct packed {
		logic sys;
		logic clk_mon;
		logic watchdog;
	} reset_req_type;
endpackage : vector_unit_pkg

// ==== verification/core_side_model.sv ====
// Core-side partner: issues vector fetches and captures the vector
`timescale 1ns/1ns
`default_nettype none
module core_side_model
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Bench command and unit answer
	input wire logic fetch_go,
	input wire logic [15:0] vector_addr,
	// Fetch strobe and captured vector
	output logic vector_fetch,
	output logic [15:0] vec_seen,
	output logic vec_done
);
	logic fetch_wait; // Vector lands after the sampling edge
	////////////////////////////////
	// One-cycle strobe, take the vector a cycle later
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vector_fetch <= 1'h0;
			fetch_wait <= 1'h0;
			vec_done <= 1'h0;
			vec_seen <= 16'h0000;
		end
		else
		begin
			vector_fetch <= fetch_go && !vector_fetch;
			fetch_wait <= vector_fetch;
			vec_done <= fetch_wait;
			if (fetch_wait)
				vec_seen <= vector_addr;
		end
	end
endmodule : core_side_model
`default_nettype wire

// ==== verification/exception_vector_priority_unit_tb.sv ====
// Bench for the exception vector priority unit
`timescale 1ns/1ns
`default_nettype none
module exception_vector_priority_unit_tb import vector_unit_pkg::*;;
	logic clk_sys;
	logic arst_n;
	reg_req_type reg_req; // Register strobes
	logic [7:0] reg_rdata;
	core_state_type core_state; // i_mask, x_mask, special
	logic [8:0] src; // Sources, top bit is system reset
	logic block_i;
	logic block_x;
	logic fetch_go; // Asks the core model to fetch
	logic vector_fetch;
	logic [15:0] vector_addr;
	logic [15:0] vec_seen;
	logic vec_done;
	logic i_pending;
	logic x_pending;
	logic wake_up;
	int error_cnt;
	int total_checks;
	// Vector expected while sources 0..n are active
	logic [15:0] exp_tab [9] = '{16'hFF00, 16'hFF80, 16'hFFF4, 16'hFFF6,
		16'hFFF6, 16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFE};
	////////////////////////////////
	exception_vector_priority_unit u_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.core_state(core_state), .i_request(122'(src[0]) | (122'(src[1]) << 64)),
		.x_request_pin(src[2]), .software_interrupt(src[4]),
		.debug_entry_request(src[3]), .opcode_trap(src[5]),
		.reset_req(reset_req_type'(src[8:6])), .block_i(block_i), .block_x(block_x),
		.vector_fetch(vector_fetch), .vector_addr(vector_addr),
		.i_pending(i_pending), .x_pending(x_pending), .wake_up(wake_up));
	core_side_model u_core (
		.clk_sys(clk_sys), .arst_n(arst_n), .fetch_go(fetch_go),
		.vector_addr(vector_addr), .vector_fetch(vector_fetch),
		.vec_seen(vec_seen), .vec_done(vec_done));
	////////////////////////////////
	// Compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk_sys);
		reg_req <= '0;
	endtask : wr
	// Read; data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk_sys);
		reg_req <= '0;
		#1;
		check({8'h00, reg_rdata}, {8'h00, e});
	endtask : rd
	// Vector fetch through the core model, bounded wait
	task automatic fetch(input logic [15:0] e);
		int wt;
		wt = 0;
		@(posedge clk_sys);
		fetch_go <= 1'h1;
		@(posedge clk_sys);
		fetch_go <= 1'h0;
		while (vec_done !== 1'h1 && wt < 8)
		begin
			@(posedge clk_sys);
			#1;
			wt++;
		end
		if (vec_done !== 1'h1)
		begin
			error_cnt++;
			stop_test();
		end
		else
		begin
			check(vec_seen, e);
		end
	endtask : fetch
	// Let registered flags follow their cause
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : settle
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	////////////////////////////////
	// Reset values, unmapped read, fetch with nothing ever pending
	task automatic t_reset();
		rd(8'h15, 8'h00);
		rd(8'h1F, 8'hF2);
		rd(8'h20, 8'h00);
		fetch(16'hFFF6);
		$display("reset test done");
	endtask : t_reset
	// All sources up, drop the winner one by one
	task automatic t_priority();
		src <= 9'h1FF;
		for (int n = 8; n >= 0; n--)
		begin
			fetch(exp_tab[n]);
			src[n] <= 1'h0;
		end
		$display("priority test done");
	endtask : t_priority
	// Promote the lowest I source; write needs the I mask
	task automatic t_promote();
		core_state <= 3'h6;
		wr(8'h1F, 8'h00);
		rd(8'h1F, 8'h00);
		core_state <= 3'h0;
		src <= 9'h003;
		fetch(16'hFF00);
		wr(8'h1F, 8'hF2);
		rd(8'h1F, 8'h00);
		src <= 9'h000;
		$display("promote test done");
	endtask : t_promote
	// Test control and force registers
	task automatic t_force();
		core_state <= 3'h6;
		src <= 9'h001;
		wr(8'h15, 8'h13);
		rd(8'h15, 8'h03);
		rd(8'h16, 8'h00);
		core_state <= 3'h7;
		wr(8'h15, 8'h00);
		wr(8'h16, 8'hFF);
		rd(8'h16, 8'h01);
		wr(8'h15, 8'h10);
		src <= 9'h000;
		rd(8'h15, 8'h10);
		rd(8'h16, 8'h01);
		wr(8'h16, 8'h04);
		rd(8'h16, 8'h04);
		core_state <= 3'h1;
		wr(8'h16, 8'h08);
		rd(8'h16, 8'h04);
		src <= 9'h002;
		fetch(16'hFF04);
		core_state <= 3'h7;
		wr(8'h15, 8'h1F);
		wr(8'h16, 8'hFF);
		rd(8'h16, 8'h07);
		core_state <= 3'h6;
		rd(8'h16, 8'h00);
		core_state <= 3'h7;
		wr(8'h15, 8'h00);
		$display("force test done");
	endtask : t_force
	// Pending flags, blocking inputs, wake from the x pin
	task automatic t_pending();
		core_state <= 3'h0;
		src <= 9'h001;
		settle();
		check({14'h0000, i_pending, wake_up}, 16'h0003);
		block_i <= 1'h1;
		settle();
		check({14'h0000, i_pending, wake_up}, 16'h0001);
		src <= 9'h004;
		core_state <= 3'h2;
		settle();
		check({14'h0000, x_pending, wake_up}, 16'h0001);
		core_state <= 3'h0;
		settle();
		check(16'(x_pending), 16'h0001);
		block_x <= 1'h1;
		settle();
		check(16'(x_pending), 16'h0000);
		$display("pending test done");
	endtask : t_pending
	////////////////////////////////
	// Clock
	initial
	begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Main sequence
	initial
	begin
		arst_n = 1'h0;
		reg_req = '0;
		core_state = '0;
		src = '0;
		block_i = 1'h0;
		block_x = 1'h0;
		fetch_go = 1'h0;
		error_cnt = 0;
		total_checks = 0;
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'h1;
		t_reset();
		t_priority();
		t_promote();
		t_force();
		t_pending();
		stop_test();
	end
endmodule : exception_vector_priority_unit_tb
`default_nettype wire
